// >>> rtl/chirq_aggregator.sv
// Channel level interrupt status aggregator with master enables
`timescale 1ns/100ps
`default_nettype none
`include "chirq_params.svh"
module chirq_aggregator
#(
   parameter int CHANNELS = 12,
   parameter int SOURCES  = 8
)
(
   // Clock and reset
   input  wire logic                          clk_sys_i,
   input  wire logic                          reset_i,
   // Register port
   input  wire chirq_pkg::reg_addr_t          addr_i,
   input  wire chirq_pkg::reg_data_t          wdata_i,
   input  wire logic                          wr_i,
   input  wire logic                          rd_i,
   output chirq_pkg::reg_data_t               rdata_o,
   // Source level flags and enables, channel major
   input  wire logic [CHANNELS*SOURCES-1:0]   src_flag_i,
   input  wire logic [CHANNELS*SOURCES-1:0]   src_enable_i,
   // Host read of a channel's source-level status register
   input  wire logic [CHANNELS-1:0]           src_status_read_i,
   // Host interrupt and flags
   output logic                               irq_o,
   output logic [CHANNELS-1:0]                pending_o
);
   import chirq_pkg::*;

   // ---------------------------------------------------------------------
   // Parameter check
   // ---------------------------------------------------------------------
   if (CHANNELS != 2*`CHIRQ_FIELD_WIDTH || SOURCES < 1)
   begin : g_bad
      $error("CHANNELS must be 12 and SOURCES at least 1");
   end

   localparam int W = `CHIRQ_FIELD_WIDTH;

   // ---------------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------------
   wire sel_en_low   = (addr_i == `CHIRQ_ADDR_MASTER_EN_LOW);
   wire sel_en_high  = (addr_i == `CHIRQ_ADDR_MASTER_EN_HIGH);
   wire sel_pnd_low  = (addr_i == `CHIRQ_ADDR_PENDING_LOW);
   wire sel_pnd_high = (addr_i == `CHIRQ_ADDR_PENDING_HIGH);

   // ---------------------------------------------------------------------
   // Master enable registers
   // ---------------------------------------------------------------------
   logic [W-1:0] men_low_q;
   logic [W-1:0] men_high_q;

   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         men_low_q  <= `CHIRQ_MASTER_EN_RESET;
         men_high_q <= `CHIRQ_MASTER_EN_RESET;
      end
      else if (wr_i)
      begin
         if (sel_en_low)
            men_low_q <= wdata_i[W-1:0];
         if (sel_en_high)
            men_high_q <= wdata_i[W-1:0];
      end
   end

   wire [CHANNELS-1:0] master_en = {men_high_q, men_low_q};

   // ---------------------------------------------------------------------
   // Per channel source OR and sticky flag
   // ---------------------------------------------------------------------
   wire [CHANNELS-1:0] chan_event;
   wire [CHANNELS-1:0] flag;

   for (genvar c = 0; c < CHANNELS; c++)
   begin : g_chan
      wire [SOURCES-1:0] hit = src_flag_i[c*SOURCES +: SOURCES]
                             & src_enable_i[c*SOURCES +: SOURCES];
      // Enabled sources gated by the master enable
      assign chan_event[c] = (|hit) & master_en[c];

      chirq_flag u_flag
      (
         .clk_sys_i (clk_sys_i),
         .reset_i   (reset_i),
         .set_i     (chan_event[c]),
         .clear_i   (src_status_read_i[c]),
         .flag_o    (flag[c])
      );
   end

   // ---------------------------------------------------------------------
   // Read mux; writes to status registers have no effect
   // ---------------------------------------------------------------------
   logic [7:0] rdata_d;
   always_comb
   begin
      rdata_d = 8'h00;
      if (sel_pnd_low)
         rdata_d = {`CHIRQ_RESERVED_READ, flag[W-1:0]};
      else if (sel_pnd_high)
         rdata_d = {`CHIRQ_RESERVED_READ, flag[CHANNELS-1:W]};
      else if (sel_en_low)
         rdata_d = {`CHIRQ_RESERVED_READ, men_low_q};
      else if (sel_en_high)
         rdata_d = {`CHIRQ_RESERVED_READ, men_high_q};
   end

   // ---------------------------------------------------------------------
   // Registered outputs
   // ---------------------------------------------------------------------
   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         rdata_o   <= 8'h00;
         irq_o     <= 1'b0;
         pending_o <= 12'h000;
      end
      else
      begin
         if (rd_i)
            rdata_o <= rdata_d;
         irq_o     <= |flag;
         pending_o <= flag;
      end
   end

   // ---------------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------------
   // Event on a channel sets its flag on the next edge
   property p_set_sticky;
      @(posedge clk_sys_i) disable iff (reset_i)
      chan_event[0] |=> flag[0];
   endproperty
   a_set_sticky: assert property (p_set_sticky)
      else $error("flag 0 not set");

   property p_hold;
      @(posedge clk_sys_i) disable iff (reset_i)
      flag[3] && !src_status_read_i[3] |=> flag[3];
   endproperty
   a_hold: assert property (p_hold)
      else $error("flag 3 dropped early");

   property p_clear;
      @(posedge clk_sys_i) disable iff (reset_i)
      src_status_read_i[2] && !chan_event[2] |=> !flag[2];
   endproperty
   a_clear: assert property (p_clear)
      else $error("flag 2 not cleared");

   // Masked channel never raises its flag
   property p_masked;
      @(posedge clk_sys_i) disable iff (reset_i)
      !master_en[0] && !flag[0] |=> !flag[0];
   endproperty
   a_masked: assert property (p_masked)
      else $error("masked channel 0 fired");

   property p_rd_low;
      @(posedge clk_sys_i) disable iff (reset_i)
      rd_i && sel_pnd_low |=> rdata_o == {2'h0, $past(flag[5:0])};
   endproperty
   a_rd_low: assert property (p_rd_low)
      else $error("low status read wrong");

   property p_rd_high;
      @(posedge clk_sys_i) disable iff (reset_i)
      rd_i && sel_pnd_high |=> rdata_o == {2'h0, $past(flag[11:6])};
   endproperty
   a_rd_high: assert property (p_rd_high)
      else $error("high status read wrong");

   property p_ro;
      @(posedge clk_sys_i) disable iff (reset_i)
      wr_i && sel_pnd_low && flag[1] && !src_status_read_i[1] |=> flag[1];
   endproperty
   a_ro: assert property (p_ro)
      else $error("write changed status");

   property p_or;
      @(posedge clk_sys_i) disable iff (reset_i)
      master_en[4] && |(src_flag_i[4*SOURCES +: SOURCES]
                      & src_enable_i[4*SOURCES +: SOURCES])
      |=> flag[4] ##1 irq_o;
   endproperty
   a_or: assert property (p_or)
      else $error("channel 4 OR lost");

   // Quiet channel keeps a clear flag
   property p_quiet;
      @(posedge clk_sys_i) disable iff (reset_i)
      !chan_event[9] && !flag[9] |=> !flag[9];
   endproperty
   a_quiet: assert property (p_quiet)
      else $error("flag 9 set with no event");

   // Host interrupt follows the OR of the flags
   property p_irq;
      @(posedge clk_sys_i) disable iff (reset_i)
      1'b1 |=> irq_o == (|$past(flag));
   endproperty
   a_irq: assert property (p_irq)
      else $error("irq output wrong");

   property p_pending;
      @(posedge clk_sys_i) disable iff (reset_i)
      1'b1 |=> pending_o == $past(flag);
   endproperty
   a_pending: assert property (p_pending)
      else $error("pending output wrong");

   // Reserved bits always read zero
   property p_reserved;
      @(posedge clk_sys_i) disable iff (reset_i)
      rd_i |=> rdata_o[7:6] == `CHIRQ_RESERVED_READ;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved bits not zero");

   // Master enable write lands on the next edge
   property p_men_wr;
      @(posedge clk_sys_i) disable iff (reset_i)
      wr_i && sel_en_high |=> men_high_q == $past(wdata_i[W-1:0]);
   endproperty
   a_men_wr: assert property (p_men_wr)
      else $error("master enable write lost");

   property p_ro_high;
      @(posedge clk_sys_i) disable iff (reset_i)
      wr_i && sel_pnd_high && flag[8] && !src_status_read_i[8] |=> flag[8];
   endproperty
   a_ro_high: assert property (p_ro_high)
      else $error("write changed high status");
endmodule
`default_nettype wire

// >>> rtl/chirq_params.svh
// Offsets, field positions and reset values for channel interrupt status
`ifndef CHIRQ_PARAMS_SVH
`define CHIRQ_PARAMS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define CHIRQ_ADDR_MASTER_EN_LOW  8'h60
`define CHIRQ_ADDR_PENDING_LOW    8'h61
`define CHIRQ_ADDR_MASTER_EN_HIGH 8'he0
`define CHIRQ_ADDR_PENDING_HIGH   8'he1

// ----------------------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------------------
`define CHIRQ_FIELD_LSB           0
`define CHIRQ_FIELD_WIDTH         6
`define CHIRQ_HIGH_FIRST_CHANNEL  6
`define CHIRQ_MASTER_EN_RESET     6'h00
`define CHIRQ_PENDING_RESET       6'h00
`define CHIRQ_RESERVED_READ       2'h0

`endif

// >>> rtl/chirq_pkg.sv
// Types shared by the channel interrupt status aggregator
package chirq_pkg;
   typedef logic [7:0] reg_data_t;
   typedef logic [7:0] reg_addr_t;
endpackage

// >>> rtl/chirq_flag.sv
// One sticky pending flag for one channel
`timescale 1ns/100ps
`default_nettype none
module chirq_flag
(
   // Clock and reset
   input  wire logic clk_sys_i,
   input  wire logic reset_i,
   // Event and clear
   input  wire logic set_i,
   input  wire logic clear_i,
   // Flag
   output logic      flag_o
);
   // ---------------------------------------------------------------------
   // Sticky flag, set wins over clear
   // ---------------------------------------------------------------------
   logic flag_d;
   assign flag_d = set_i | (flag_o & ~clear_i);

   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
         flag_o <= 1'b0;
      else
         flag_o <= flag_d;
   end
endmodule
`default_nettype wire

// >>> tb/chirq_src_model.sv
// Source-level interrupt model: sticky flags cleared by a service read
`timescale 1ns/100ps
`default_nettype none
module chirq_src_model
(
   // Clock and reset
   input  wire logic        clk_sys_i,
   input  wire logic        reset_i,
   // Events, enables and service requests
   input  wire logic [95:0] raise_i,
   input  wire logic [95:0] enable_i,
   input  wire logic [11:0] svc_i,
   // Toward the aggregator
   output logic      [95:0] src_flag_o,
   output logic      [95:0] src_enable_o,
   output logic      [11:0] src_status_read_o
);
   assign src_enable_o = enable_i;
   // Read pulse is registered on the same edge as the source clear, so the flag cannot re-set
   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         src_flag_o <= '0;
         src_status_read_o <= '0;
      end
      else
      begin
         for (int c = 0; c < 12; c++)
            if (svc_i[c])
               src_flag_o[c*8 +: 8] <= 8'h00;
            else
               src_flag_o[c*8 +: 8] <= src_flag_o[c*8 +: 8] | raise_i[c*8 +: 8];
         src_status_read_o <= svc_i;
      end
   end
endmodule
`default_nettype wire

// >>> tb/channel_irq_status_aggregator_tb_top.sv
// Register-level testbench for the channel interrupt status aggregator
`timescale 1ns/100ps
`default_nettype none
module channel_irq_status_aggregator_tb_top;
   import chirq_pkg::*;
   logic        clk_sys_i, reset_i, wr_i, rd_i, irq_o;
   reg_addr_t   addr_i, ra;
   reg_data_t   wdata_i, rdata_o;
   logic [95:0] raise, en, src_flag, src_en;
   logic [11:0] svc, src_rd, pending_o;
   int          failures = 0, n_checks = 0, cyc = 0, c;

   chirq_aggregator dut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
      .rdata_o(rdata_o), .src_flag_i(src_flag), .src_enable_i(src_en),
      .src_status_read_i(src_rd), .irq_o(irq_o), .pending_o(pending_o));
   chirq_src_model src (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
      .raise_i(raise), .enable_i(en), .svc_i(svc), .src_flag_o(src_flag),
      .src_enable_o(src_en), .src_status_read_o(src_rd));

   // Clock and hang guard
   initial
   begin
      clk_sys_i = 1'b0;
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end
   always @(posedge clk_sys_i)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         failures++;
         stop_test();
      end
   end

   task automatic stop_test;
      $display("checks=%0d failures=%0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         failures++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk_sys_i);
   endtask
   task automatic wr(input reg_addr_t a, input reg_data_t d);
      addr_i = a;
      wdata_i = d;
      wr_i = 1'b1;
      tick(1);
      wr_i = 1'b0;
      tick(1);
   endtask
   task automatic rdchk(input reg_addr_t a, input reg_data_t e);
      addr_i = a;
      rd_i = 1'b1;
      tick(1);
      rd_i = 1'b0;
      tick(1);
      chk(16'(rdata_o), 16'(e));
   endtask

   // Main sequence
   initial
   begin
      reset_i = 1'b1;
      {wr_i, rd_i, addr_i, wdata_i, raise, en, svc} = '0;
      tick(9);
      reset_i = 1'b0;
      tick(1);
      rdchk(8'h61, 8'h00);
      rdchk(8'he1, 8'h00);
      rdchk(8'h33, 8'h00);
      wr(8'h60, 8'h3f);
      wr(8'he0, 8'h3f);
      rdchk(8'he0, 8'h3f);
      rdchk(8'h60, 8'h3f);
      for (c = 0; c < 12; c++)
      begin
         ra = (c < 6) ? 8'h61 : 8'he1;
         en[c*8 + c%8] = 1'b1;
         raise[c*8 + c%8] = 1'b1;
         tick(1);
         raise = '0;
         tick(3);
         chk(16'(pending_o), 16'(1) << c);
         chk(16'(irq_o), 16'h1);
         rdchk(ra, 8'h01 << (c % 6));
         wr(ra, 8'h00);
         en = '0;
         tick(3);
         rdchk(ra, 8'h01 << (c % 6));
         svc[c] = 1'b1;
         tick(1);
         svc = '0;
         tick(4);
         chk(16'(pending_o), 16'h0);
         chk(16'(irq_o), 16'h0);
      end
      // Master off for channel 0, source enable off for channel 1
      wr(8'h60, 8'h3e);
      en[0] = 1'b1;
      raise[0] = 1'b1;
      raise[8] = 1'b1;
      tick(1);
      raise = '0;
      tick(3);
      chk(16'(pending_o), 16'h0);
      chk(16'(irq_o), 16'h0);
      wr(8'h60, 8'h3f);
      tick(3);
      chk(16'(pending_o), 16'h1);
      // Mid-run reset clears flags and master enables
      reset_i = 1'b1;
      tick(2);
      chk(16'(pending_o), 16'h0);
      reset_i = 1'b0;
      tick(1);
      rdchk(8'h60, 8'h00);
      chk(16'(irq_o), 16'h0);
      stop_test();
   end
endmodule
`default_nettype wire
